// file: tdc_top.sv
// Time-of-day clock: divider, counters, alarm, stopwatch, AXI4-Lite slave.
// Assumes the bus and CLK_SYS share one domain; OSC_IN is asynchronous.
// Summary of operation
// - Day counter increments when hours wrap from 23 to 00.
// - Day register readable and writable anytime; write replaces the count.
// - Day counter keeps its value through system reset.
// - Day count in bits 15..0, any value 0..65535; upper bits zero.
// - Alarm day in bits 15..0, any value 0..65535; upper bits reserved.
// - Alarm registers readable and writable anytime without stopping time.
// - Divide count is 32 bits built from upper and lower 16-bit registers.
// - One-second tick is input clock divided by the full divide count.
// - Sampling clock is input clock divided by divide count bits 31..9.
// - Divide count zero stops the one-second tick completely.
// - Only the one-second tick advances seconds, minutes, hours and days.
// - Seconds 6 bits, minutes 6, hours 5 sharing a register, days 16.
// - Time registers readable and writable anytime while counting goes on.
// - Each seconds increment sets the per-second event flag.
// - Seconds wrap 59 to 00 increments minutes and sets the minute flag.
// - Minute wrap bumps hours, sets hour flag; hour wrap bumps days, day flag.
// - Full time equal to alarm time raises alarm if alarm enabled.
// - Enabled alarm refires every 65536 days; software disables for one-shot.
// - Stopwatch decrements by one on each minute tick.
// - At -1 the stopwatch flags its event if stopwatch enabled, and holds until rewritten.
// - First stopwatch decrement happens at the next minute tick.
// - Enables: hour 5, second 4, day 3, alarm 2, minute 1, stopwatch 0.
// - Enabling stopwatch while at -1 posts its event on next minute tick.
// - Stopwatch count is 6 bits in 5..0, resets to all ones.
`timescale 1ns/1ps
module tdc_top
   import tdc_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic        CLK_EN,
   // Oscillator input pin
   input  wire logic        OSC_IN,
   // AXI4-Lite write address, data and response
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Derived clocks and interrupt
   output logic             SAMPLE_CLK,
   output logic             IRQ
);

   // ********************************************************
   // Oscillator synchroniser and edge
   // ********************************************************
   logic [2:0]  osc_sync_ff;
   logic        osc_rise;

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         osc_sync_ff <= 3'h0;
      end else if (CLK_EN) begin
         osc_sync_ff <= {osc_sync_ff[1:0], OSC_IN};
      end
   end
   assign osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];

   // ********************************************************
   // Divider registers and prescalers
   // ********************************************************
   logic [15:0] div_upper_ff;
   logic [15:0] div_lower_ff;
   logic [31:0] osc_divide_count;
   logic [31:0] sec_div_ff;
   logic [22:0] smp_div_ff;
   logic        sample_clk_ff;
   logic        tick;

   assign osc_divide_count = {div_upper_ff, div_lower_ff};

   // Count wraps at divide count; zero never ticks
   assign tick = osc_rise && (osc_divide_count != 32'h0) && (sec_div_ff >= osc_divide_count - 32'h1);

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         sec_div_ff <= 32'h0;
      end else if (CLK_EN && osc_rise) begin
         sec_div_ff <= tick ? 32'h0 : sec_div_ff + 32'h1;
      end
   end

   // Sampling clock toggles each half of the coarse count
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         smp_div_ff    <= 23'h0;
         sample_clk_ff <= 1'b0;
      end else if (CLK_EN && osc_rise && osc_divide_count[31:9] != 23'h0) begin
         if (smp_div_ff >= osc_divide_count[31:9] - 23'h1) begin
            smp_div_ff    <= 23'h0;
            sample_clk_ff <= 1'b1;
         end else begin
            smp_div_ff    <= smp_div_ff + 23'h1;
            if (smp_div_ff == {1'b0, osc_divide_count[31:10]} - 23'h1) begin
               sample_clk_ff <= 1'b0;
            end
         end
      end
   end
   assign SAMPLE_CLK = sample_clk_ff;

   // ********************************************************
   // Bus decode
   // ********************************************************
   logic        wr_fire;
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [7:0]  aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        bvalid_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [1:0]  bresp_ff;

   // Ready drops while frozen so no handshake is lost
   assign S_AXI_AWREADY = CLK_EN && !aw_held_ff && !bvalid_ff;
   assign S_AXI_WREADY  = CLK_EN && !w_held_ff && !bvalid_ff;
   assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   logic        wr_known;
   logic [31:0] wr_old;
   logic [31:0] wr_val;
   logic        wr_sec;
   logic        wr_hm;
   logic        wr_day;
   logic        wr_asec;
   logic        wr_ahm;
   logic        wr_aday;
   logic        wr_flag;
   logic        wr_en;
   logic        wr_sw;
   logic        wr_du;
   logic        wr_dl;

   assign wr_sec  = wr_fire && aw_addr_ff == OFS_SECONDS;
   assign wr_hm   = wr_fire && aw_addr_ff == OFS_HOUR_MIN;
   assign wr_day  = wr_fire && aw_addr_ff == OFS_DAY;
   assign wr_asec = wr_fire && aw_addr_ff == OFS_ALM_SEC;
   assign wr_ahm  = wr_fire && aw_addr_ff == OFS_ALM_HM;
   assign wr_aday = wr_fire && aw_addr_ff == OFS_ALM_DAY;
   assign wr_flag = wr_fire && aw_addr_ff == OFS_EVT_FLAG;
   assign wr_en   = wr_fire && aw_addr_ff == OFS_EVT_EN;
   assign wr_sw   = wr_fire && aw_addr_ff == OFS_STOPWATCH;
   assign wr_du   = wr_fire && aw_addr_ff == OFS_DIV_UPPER;
   assign wr_dl   = wr_fire && aw_addr_ff == OFS_DIV_LOWER;
   assign wr_val   = merge(wr_old, w_data_ff, w_strb_ff);

   // ********************************************************
   // Time-of-day counters
   // ********************************************************
   tdc_time_t   tod_ff;
   tdc_time_t   alarm_ff;
   logic [5:0]  flag_ff;
   logic [5:0]  enable_ff;
   logic [5:0]  swatch_ff;
   logic        sec_wrap;
   logic        min_wrap;
   logic        hour_wrap;
   logic        alarm_hit;

   assign sec_wrap  = tick && tod_ff.second == SEC_MAX;
   assign min_wrap  = sec_wrap && tod_ff.minute == MIN_MAX;
   assign hour_wrap = min_wrap && tod_ff.hour == HOUR_MAX;

   // No reset here: time survives system reset
   always_ff @(posedge CLK_SYS) begin
      if (CLK_EN) begin
         if (wr_sec) begin
            tod_ff.second <= wr_val[5:0];
         end else if (tick) begin
            tod_ff.second <= sec_wrap ? 6'h0 : tod_ff.second + 6'h1;
         end
         if (wr_hm) begin
            tod_ff.minute <= wr_val[HM_MIN_LSB +: 6];
            tod_ff.hour   <= wr_val[HM_HR_LSB +: 5];
         end else if (sec_wrap) begin
            tod_ff.minute <= min_wrap ? 6'h0 : tod_ff.minute + 6'h1;
            if (min_wrap) begin
               tod_ff.hour <= hour_wrap ? 5'h0 : tod_ff.hour + 5'h1;
            end
         end
         if (wr_day) begin
            tod_ff.day <= wr_val[15:0];
         end else if (hour_wrap) begin
            tod_ff.day <= tod_ff.day + 16'h1;
         end
      end
   end

   property p_day_step;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (CLK_EN && hour_wrap && !wr_day) |=> (tod_ff.day == $past(tod_ff.day) + 16'h1 && flag_ff[EVT_DAY]);
   endproperty
   a_day_step: assert property (p_day_step) else $error("day did not advance on hour wrap");

   // ********************************************************
   // Alarm and divider settings
   // ********************************************************
   // Alarm settings are kept over reset, like the time itself; the divider registers reset to zero
   always_ff @(posedge CLK_SYS) begin
      if (CLK_EN) begin
         if (wr_asec) begin
            alarm_ff.second <= wr_val[5:0];
         end
         if (wr_ahm) begin
            alarm_ff.minute <= wr_val[HM_MIN_LSB +: 6];
            alarm_ff.hour   <= wr_val[HM_HR_LSB +: 5];
         end
         if (wr_aday) begin
            alarm_ff.day <= wr_val[15:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         div_upper_ff <= 16'h0;
         div_lower_ff <= 16'h0;
      end else if (CLK_EN) begin
         if (wr_du) begin
            div_upper_ff <= wr_val[15:0];
         end
         if (wr_dl) begin
            div_lower_ff <= wr_val[15:0];
         end
      end
   end

   // Compare only on a tick so one match gives one event
   assign alarm_hit = tick && (tod_ff == alarm_ff) && enable_ff[EVT_ALARM];

   // ********************************************************
   // Stopwatch
   // ********************************************************
   // Fires on the step from 0 to -1, and each minute while parked at -1
   logic sw_fire;
   assign sw_fire = sec_wrap && enable_ff[EVT_SWATCH]
                  && (swatch_ff == 6'h0 || swatch_ff == SWATCH_RESET);

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         swatch_ff <= SWATCH_RESET;
      end else if (CLK_EN) begin
         if (wr_sw) begin
            swatch_ff <= wr_val[5:0];
         end else if (sec_wrap && swatch_ff != SWATCH_RESET) begin
            swatch_ff <= swatch_ff - 6'h1;
         end
      end
   end

   sequence s_sw_last_minute;
      CLK_EN && sec_wrap && !wr_sw && swatch_ff == 6'h0 && enable_ff[EVT_SWATCH];
   endsequence
   sequence s_sw_expired;
      swatch_ff == SWATCH_RESET && flag_ff[EVT_SWATCH];
   endsequence
   property p_sw_expire;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      s_sw_last_minute |=> s_sw_expired;
   endproperty
   a_sw_expire: assert property (p_sw_expire) else $error("stopwatch did not expire");

   property p_sw_hold;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (CLK_EN && swatch_ff == SWATCH_RESET && !wr_sw) |=> swatch_ff == SWATCH_RESET;
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("stopwatch left minus one");

   // No disable here: this one watches the reset itself
   property p_reset_vals;
      @(posedge CLK_SYS)
      !RESET_N |=> (swatch_ff == SWATCH_RESET && enable_ff == EVT_EN_RESET && flag_ff == 6'h0);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

   // ********************************************************
   // Event flags and enables
   // ********************************************************
   logic [5:0] evt_set;
   always_comb begin
      evt_set             = 6'h0;
      evt_set[EVT_SEC]    = tick;
      evt_set[EVT_MINUTE] = sec_wrap;
      evt_set[EVT_HOUR]   = min_wrap;
      evt_set[EVT_DAY]    = hour_wrap;
      evt_set[EVT_ALARM]  = alarm_hit;
      evt_set[EVT_SWATCH] = sw_fire;
   end

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         flag_ff <= 6'h0;
      end else if (CLK_EN) begin
         flag_ff <= (flag_ff & ~(wr_flag ? wr_val[5:0] : 6'h0)) | evt_set;
      end
   end

   property p_tick_stop;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (CLK_EN && osc_divide_count == 32'h0 && !flag_ff[EVT_SEC]) |=> !flag_ff[EVT_SEC];
   endproperty
   a_tick_stop: assert property (p_tick_stop) else $error("second flag set with divider at zero");

   property p_sec_flag;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (CLK_EN && tick) |=> flag_ff[EVT_SEC];
   endproperty
   a_sec_flag: assert property (p_sec_flag) else $error("second flag missing after tick");

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         enable_ff <= EVT_EN_RESET;
      end else if (CLK_EN && wr_en) begin
         enable_ff <= wr_val[5:0];
      end
   end

   assign IRQ = |(flag_ff & enable_ff);

   property p_irq_off;
      @(posedge CLK_SYS) disable iff (!RESET_N)
      (CLK_EN && wr_en && wr_val[5:0] == 6'h0) |=> !IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt high with all enables off");

   // ********************************************************
   // Read mux
   // ********************************************************
   function automatic logic [31:0] reg_read(input logic [7:0] a, output logic ok);
      logic [31:0] v;
      v  = 32'h0;
      ok = 1'b1;
      unique case (a)
         OFS_SECONDS:   v[5:0] = tod_ff.second;
         OFS_HOUR_MIN:  v = {19'h0, tod_ff.hour, 2'h0, tod_ff.minute};
         OFS_DAY:       v[15:0] = tod_ff.day;
         OFS_ALM_SEC:   v[5:0] = alarm_ff.second;
         OFS_ALM_HM:    v = {19'h0, alarm_ff.hour, 2'h0, alarm_ff.minute};
         OFS_ALM_DAY:   v[15:0] = alarm_ff.day;
         OFS_EVT_FLAG:  v[5:0] = flag_ff;
         OFS_EVT_EN:    v[5:0] = enable_ff;
         OFS_STOPWATCH: v[5:0] = swatch_ff;
         OFS_DIV_UPPER: v[15:0] = div_upper_ff;
         OFS_DIV_LOWER: v[15:0] = div_lower_ff;
         default:       ok = 1'b0;
      endcase
      return v;
   endfunction : reg_read

   logic        rd_ok;
   logic        wr_rd_ok;
   logic [31:0] rd_val;
   // Output argument needs a procedural caller
   always_comb begin
      wr_old = reg_read(aw_addr_ff, wr_rd_ok);
      rd_val = reg_read({S_AXI_ARADDR[7:2], 2'h0}, rd_ok);
   end
   assign wr_known = wr_rd_ok;

   // ********************************************************
   // AXI4-Lite handshakes
   // ********************************************************
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         aw_addr_ff <= 8'h0;
         w_data_ff  <= 32'h0;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end else if (CLK_EN) begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= {S_AXI_AWADDR[7:2], 2'h0};
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA;
            w_strb_ff <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff && S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   assign S_AXI_ARREADY = CLK_EN && !rvalid_ff;
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= RESP_OKAY;
      end else if (CLK_EN) begin
         if (S_AXI_ARVALID && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_val;
            rresp_ff  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP  = bresp_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA  = rdata_ff;
   assign S_AXI_RRESP  = rresp_ff;

endmodule : tdc_top

// file: tdc_pkg.sv
// Package for the time-of-day clock with alarm and stopwatch.
// Assumes a single system clock domain and an AXI4-Lite register bus.
package tdc_pkg;

   // ********************************************************
   // Register byte offsets
   // ********************************************************
   localparam logic [7:0] OFS_SECONDS   = 8'h00;
   localparam logic [7:0] OFS_HOUR_MIN  = 8'h04;
   localparam logic [7:0] OFS_DAY       = 8'h08;
   localparam logic [7:0] OFS_ALM_SEC   = 8'h0C;
   localparam logic [7:0] OFS_ALM_HM    = 8'h10;
   localparam logic [7:0] OFS_ALM_DAY   = 8'h14;
   localparam logic [7:0] OFS_EVT_FLAG  = 8'h18;
   localparam logic [7:0] OFS_EVT_EN    = 8'h1C;
   localparam logic [7:0] OFS_STOPWATCH = 8'h20;
   localparam logic [7:0] OFS_DIV_UPPER = 8'h24;
   localparam logic [7:0] OFS_DIV_LOWER = 8'h28;

   // ********************************************************
   // Field positions
   // ********************************************************
   localparam int EVT_HOUR   = 5;
   localparam int EVT_SEC    = 4;
   localparam int EVT_DAY    = 3;
   localparam int EVT_ALARM  = 2;
   localparam int EVT_MINUTE = 1;
   localparam int EVT_SWATCH = 0;
   localparam int HM_MIN_LSB = 0;
   localparam int HM_HR_LSB  = 8;

   // ********************************************************
   // Counts and reset values
   // ********************************************************
   localparam logic [5:0] SEC_MAX      = 6'h3B;
   localparam logic [5:0] MIN_MAX      = 6'h3B;
   localparam logic [4:0] HOUR_MAX     = 5'h17;
   localparam logic [5:0] SWATCH_RESET = 6'h3F;
   localparam logic [5:0] EVT_EN_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // ********************************************************
   // Time-of-day value
   // ********************************************************
   typedef struct packed {
      logic [15:0] day;
      logic [4:0]  hour;
      logic [5:0]  minute;
      logic [5:0]  second;
   } tdc_time_t;

endpackage : tdc_pkg

// file: tb_tdc_top.sv
// Self-checking bench for the time-of-day clock with alarm and stopwatch.
// Assumes tdc_pkg and tdc_top are compiled first; OSC_IN edges are made by hand.
`timescale 1ns/1ps
module tb_tdc_top
   import tdc_pkg::*;
;
   // ********************************************************
   // Signals
   // ********************************************************
   logic        clk_sys, reset_n, clk_en, osc_in;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        sample_clk, irq;
   int          miscompares, checked;

   tdc_top i_tdc_top (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en), .OSC_IN(osc_in),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SAMPLE_CLK(sample_clk), .IRQ(irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ********************************************************
   // Shared tasks
   // ********************************************************
   task automatic end_sim;
      $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic hang(input string what);
      miscompares++;
      $display("wrong value at %0t: %s timed out", $time, what);
      end_sim();
   endtask : hang

   // Both channels offered together; each released on its own ready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                         input logic [1:0] er = RESP_OKAY);
      int n;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      if (n == 40)
         hang("write");
      chk({30'h0, bresp}, {30'h0, er}, "write resp");
      @(posedge clk_sys);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
      int n;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
      if (n == 40)
         hang("read");
      chk(rdata, exp, "read data");
      chk({30'h0, rresp}, {30'h0, er}, "read resp");
      @(posedge clk_sys);
   endtask : axi_rd

   // Slow pulses so the two-flop synchroniser never misses an edge
   task automatic tick(input int n);
      repeat (n) begin
         osc_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         osc_in <= 1'b0;
         repeat (6) @(posedge clk_sys);
      end
   endtask : tick

   task automatic do_reset;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
   endtask : do_reset

   // ********************************************************
   // Scenarios
   // ********************************************************
   task automatic t_reset;
      axi_rd(OFS_EVT_EN, {26'h0, EVT_EN_RESET});
      axi_rd(OFS_STOPWATCH, {26'h0, SWATCH_RESET});
      axi_rd(OFS_EVT_FLAG, 32'h0);
      axi_rd(OFS_DIV_LOWER, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq idle");
      axi_rd(8'h40, 32'h0, RESP_SLVERR);
      axi_wr(8'h40, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      axi_wr(OFS_DAY, 32'h1234ABCD, 4'h3);
      axi_rd(OFS_DAY, 32'h0000ABCD);
      axi_wr(OFS_ALM_DAY, 32'h5678FFFF, 4'h3);
      axi_rd(OFS_ALM_DAY, 32'h0000FFFF);
      axi_wr(OFS_DIV_UPPER, 32'h0000A5A5);
      axi_rd(OFS_DIV_UPPER, 32'h0000A5A5);
      axi_wr(OFS_DIV_LOWER, 32'h00005A5A);
      axi_rd(OFS_DIV_LOWER, 32'h00005A5A);
      do_reset();
      axi_rd(OFS_DAY, 32'h0000ABCD);
      axi_rd(OFS_DIV_UPPER, 32'h0);
      $display("test registers done");
   endtask : t_regs

   task automatic t_roll;
      axi_wr(OFS_DIV_LOWER, 32'h1);
      axi_wr(OFS_SECONDS, {26'h0, SEC_MAX});
      axi_wr(OFS_HOUR_MIN, {19'h0, HOUR_MAX, 2'h0, MIN_MAX});
      axi_wr(OFS_DAY, 32'h0000FFFF, 4'h3);
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      tick(1);
      axi_rd(OFS_SECONDS, 32'h0);
      axi_rd(OFS_HOUR_MIN, 32'h0);
      axi_rd(OFS_DAY, 32'h0);
      axi_rd(OFS_EVT_FLAG, 32'h3A);
      tick(1);
      axi_rd(OFS_SECONDS, 32'h1);
      $display("test rollover done");
   endtask : t_roll

   task automatic t_irq;
      axi_wr(OFS_EVT_EN, 32'h10);
      axi_rd(OFS_EVT_EN, 32'h10);
      chk({31'h0, irq}, 32'h1, "irq on");
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      chk({31'h0, irq}, 32'h0, "irq off");
      axi_rd(OFS_EVT_FLAG, 32'h0);
      axi_wr(OFS_EVT_EN, 32'h0);
      $display("test interrupt done");
   endtask : t_irq

   task automatic t_zero;
      axi_wr(OFS_DIV_LOWER, 32'h0);
      axi_wr(OFS_SECONDS, 32'h5);
      tick(2);
      axi_rd(OFS_SECONDS, 32'h5);
      axi_rd(OFS_EVT_FLAG, 32'h0);
      $display("test stopped divider done");
   endtask : t_zero

   // Coarse count of two: sampling clock stays low on edge 1, then toggles each oscillator edge
   task automatic t_sample;
      axi_wr(OFS_DIV_LOWER, 32'h400);
      chk({31'h0, sample_clk}, 32'h0, "sample clock start");
      tick(1);
      chk({31'h0, sample_clk}, 32'h0, "sample clock edge 1");
      tick(1);
      chk({31'h0, sample_clk}, 32'h1, "sample clock edge 2");
      tick(1);
      chk({31'h0, sample_clk}, 32'h0, "sample clock edge 3");
      $display("test sample clock done");
   endtask : t_sample

   task automatic t_alarm;
      axi_wr(OFS_DIV_LOWER, 32'h1);
      axi_wr(OFS_SECONDS, 32'h0A);
      axi_wr(OFS_HOUR_MIN, 32'h0102);
      axi_wr(OFS_DAY, 32'h7, 4'h3);
      axi_wr(OFS_ALM_SEC, 32'h0A);
      axi_wr(OFS_ALM_HM, 32'h0102);
      axi_wr(OFS_ALM_DAY, 32'h7, 4'h3);
      tick(1);
      axi_rd(OFS_EVT_FLAG, 32'h10);
      axi_wr(OFS_SECONDS, 32'h0A);
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      axi_wr(OFS_EVT_EN, 32'h04);
      tick(1);
      axi_rd(OFS_EVT_FLAG, 32'h14);
      chk({31'h0, irq}, 32'h1, "alarm irq");
      axi_wr(OFS_EVT_EN, 32'h0);
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      $display("test alarm done");
   endtask : t_alarm

   task automatic t_swatch;
      axi_wr(OFS_SECONDS, 32'h1E);
      axi_wr(OFS_STOPWATCH, 32'h1);
      clk_en <= 1'b0;
      tick(1);
      clk_en <= 1'b1;
      tick(1);
      axi_rd(OFS_SECONDS, 32'h1F);
      axi_rd(OFS_STOPWATCH, 32'h1);
      axi_wr(OFS_SECONDS, {26'h0, SEC_MAX});
      tick(1);
      axi_rd(OFS_STOPWATCH, 32'h0);
      axi_wr(OFS_SECONDS, {26'h0, SEC_MAX});
      tick(1);
      axi_rd(OFS_STOPWATCH, 32'h3F);
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      axi_wr(OFS_EVT_EN, 32'h01);
      axi_wr(OFS_SECONDS, {26'h0, SEC_MAX});
      tick(1);
      axi_rd(OFS_EVT_FLAG, 32'h13);
      axi_rd(OFS_STOPWATCH, 32'h3F);
      chk({31'h0, irq}, 32'h1, "stopwatch irq");
      axi_wr(OFS_STOPWATCH, 32'h0);
      axi_wr(OFS_EVT_FLAG, 32'h3F);
      axi_wr(OFS_SECONDS, {26'h0, SEC_MAX});
      tick(1);
      axi_rd(OFS_EVT_FLAG, 32'h13);
      axi_rd(OFS_STOPWATCH, 32'h3F);
      $display("test stopwatch done");
   endtask : t_swatch

   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      miscompares = 0;
      checked     = 0;
      clk_en      = 1'b1;
      reset_n     = 1'b0;
      osc_in      = 1'b0;
      awaddr      = 8'h00;
      araddr      = 8'h00;
      wdata       = 32'h0;
      wstrb       = 4'h0;
      awvalid     = 1'b0;
      wvalid      = 1'b0;
      bready      = 1'b0;
      arvalid     = 1'b0;
      rready      = 1'b0;
      do_reset();
      t_reset();
      t_regs();
      t_roll();
      t_irq();
      t_zero();
      t_sample();
      t_alarm();
      t_swatch();
      end_sim();
   end

endmodule : tb_tdc_top
